// file: rtl/wdt_ctrl_lock.sv
// watchdog control register with permanent lock, apb slave, sync busy
//
// Functional notes
// - 8-bit control: lock7, standby6, window2, enable1
// - lock set sticks until power-on reset
// - lock makes control, period, warning read-only
// - lock bit writable while watchdog enabled
// - lock, standby, window loaded from user row
// - lock clear: enable bit alone starts/stops
// - standby writes need enable low and lock clear
// - standby bit chooses halt or run asleep
// - window writes need disabled and lock clear
// - window bit picks normal or windowed mode
`timescale 1ns/1ps
`include "wdt_ctrl_defs.svh"
module wdt_ctrl_lock
    import wdt_ctrl_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        wdt_clk,
    input  wire logic        nvm_load,
    input  wire logic        nvm_lock,
    input  wire logic        nvm_stdby_run,
    input  wire logic        nvm_window_en,
    input  wire logic        nvm_enable,
    input  wire logic        standby_sleep,
    output logic             wdt_running,
    output logic             wdt_count_en,
    output logic             wdt_window_mode,
    output logic             sync_busy,
    output logic [7:0]       period_config,
    output logic [7:0]       early_warning_setup
);
    import wdt_ctrl_pkg::*;

    ctrl_byte_t  ctrl_q;
    ctrl_byte_t  ctrl_d;
    ctrl_byte_t  wdt_shadow;
    sync_state_e sync_q;
    logic        req_tgl_q;
    logic        ack_tgl;
    logic        ack_s;
    logic        load_s;
    logic        load_seen_q;
    logic        stdby_s;
    logic        wr_acc;
    logic        rd_acc;
    logic        ctrl_wr;

    // register decode, used for both read and write
    function automatic logic [2:0] reg_sel(input logic [11:0] a);
        case (a)
            `OFS_CONTROL_PRIMARY:     reg_sel = 3'h1;
            `OFS_PERIOD_CONFIG:       reg_sel = 3'h2;
            `OFS_EARLY_WARNING_SETUP: reg_sel = 3'h3;
            `OFS_SYNC_STATUS:         reg_sel = 3'h4;
            default:                  reg_sel = 3'h0;
        endcase
    endfunction

    assign wr_acc = psel && penable && pwrite && pready;
    assign rd_acc = psel && !pwrite && !penable;
    // every accepted control write made while idle and unlocked is synchronised,
    // even one that leaves the byte unchanged, so software always sees busy
    assign ctrl_wr = wr_acc && reg_sel(paddr) == 3'h1 && pstrb[0] &&
                     !ctrl_q[`BIT_LOCK];

    // load strobe and sleep inputs pass two flops; strap values are sampled directly
    wdt_bit_sync u_load (
        .clk   (pclk),
        .rst_n (presetn),
        .din   (nvm_load),
        .dout  (load_s)
    );
    wdt_bit_sync u_stdby (
        .clk   (pclk),
        .rst_n (presetn),
        .din   (standby_sleep),
        .dout  (stdby_s)
    );
    wdt_bit_sync u_ack (
        .clk   (pclk),
        .rst_n (presetn),
        .din   (ack_tgl),
        .dout  (ack_s)
    );

    // next control value, guarded per field
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_acc && reg_sel(paddr) == 3'h1 && pstrb[0] &&
            sync_q == st_idle) begin
            if (!ctrl_q[`BIT_LOCK]) begin
                ctrl_d[`BIT_ENABLE] = pwdata[`BIT_ENABLE];
                if (pwdata[`BIT_LOCK])
                    ctrl_d[`BIT_LOCK] = 1'b1;
                if (!ctrl_q[`BIT_ENABLE])
                    ctrl_d[`BIT_STDBY_RUN] = pwdata[`BIT_STDBY_RUN];
                if (!ctrl_q[`BIT_ENABLE])
                    ctrl_d[`BIT_WINDOW_EN] = pwdata[`BIT_WINDOW_EN];
            end
        end
    end

    // control byte; only presetn (power-on) clears the lock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q      <= 8'h00;
            load_seen_q <= 1'b0;
        end else if (load_s && !load_seen_q) begin
            ctrl_q[`BIT_LOCK]      <= nvm_lock;
            ctrl_q[`BIT_STDBY_RUN] <= nvm_stdby_run;
            ctrl_q[`BIT_WINDOW_EN] <= nvm_window_en;
            ctrl_q[`BIT_ENABLE]    <= nvm_enable | nvm_lock;
            load_seen_q            <= 1'b1;
        end else begin
            ctrl_q <= ctrl_d;
            if (ctrl_d[`BIT_LOCK])
                ctrl_q[`BIT_ENABLE] <= 1'b1;
        end
    end

    // period and warning setup, frozen by lock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_config       <= `CONFIG_RESET;
            early_warning_setup <= `EW_RESET;
        end else if (wr_acc && pstrb[0] && !ctrl_q[`BIT_LOCK]) begin
            if (reg_sel(paddr) == 3'h2)
                period_config <= pwdata[7:0] & `CONFIG_MASK;
            if (reg_sel(paddr) == 3'h3)
                early_warning_setup <= pwdata[7:0] & `EW_MASK;
        end
    end

    // handshake into the watchdog clock domain
    // toggle request, busy until ack
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_q    <= st_idle;
            req_tgl_q <= 1'b0;
            sync_busy <= 1'b0;
        end else begin
            case (sync_q)
                st_idle: begin
                    if (ctrl_wr || (load_s && !load_seen_q)) begin
                        req_tgl_q <= ~req_tgl_q;
                        sync_busy <= 1'b1;
                        sync_q    <= st_wait_ack;
                    end
                end
                st_wait_ack: begin
                    if (ack_s == req_tgl_q) begin
                        sync_busy <= 1'b0;
                        sync_q    <= st_idle;
                    end
                end
                default: sync_q <= st_idle;
            endcase
        end
    end

    // ctrl_q is held stable while busy, so the copy is coherent
    wdt_ctrl_shadow u_shadow (
        .clk     (wdt_clk),
        .rst_n   (presetn),
        .req_tgl (req_tgl_q),
        .data    (ctrl_q),
        .shadow  (wdt_shadow),
        .ack_tgl (ack_tgl)
    );

    // running and window status registered on pclk after sync completes; count gate updates while busy too
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_running     <= 1'b0;
            wdt_count_en    <= 1'b0;
            wdt_window_mode <= 1'b0;
        end else if (!sync_busy) begin
            wdt_running     <= ctrl_q[`BIT_ENABLE];
            // halt in standby unless run bit
            wdt_count_en    <= ctrl_q[`BIT_ENABLE] &&
                               (!stdby_s || ctrl_q[`BIT_STDBY_RUN]);
            wdt_window_mode <= ctrl_q[`BIT_WINDOW_EN];
        end else begin
            wdt_count_en    <= wdt_running &&
                               (!stdby_s || ctrl_q[`BIT_STDBY_RUN]);
        end
    end

    // apb: no wait states, reads latched in setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && reg_sel(paddr) == 3'h0;
            if (rd_acc) begin
                case (reg_sel(paddr))
                    3'h1:    prdata <= {24'h00_0000, ctrl_q};
                    3'h2:    prdata <= {24'h00_0000, period_config};
                    3'h3:    prdata <= {24'h00_0000, early_warning_setup};
                    3'h4:    prdata <= {31'h0000_0000, sync_busy};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // wdt_ctrl_lock

// file: inc/wdt_ctrl_defs.svh
// register offsets, field positions and reset constants of the watchdog control
`ifndef WDT_CTRL_DEFS_SVH
`define WDT_CTRL_DEFS_SVH

`define OFS_CONTROL_PRIMARY      12'h000
`define OFS_PERIOD_CONFIG        12'h004
`define OFS_EARLY_WARNING_SETUP  12'h008
`define OFS_SYNC_STATUS          12'h00C
`define OFS_STANDBY_CTRL         12'h010

`define BIT_LOCK                 7
`define BIT_STDBY_RUN            6
`define BIT_WINDOW_EN            2
`define BIT_ENABLE               1

`define CONFIG_MASK              8'hFF
`define EW_MASK                  8'h0F
`define CONFIG_RESET             8'h00
`define EW_RESET                 8'h00

`endif

// file: inc/wdt_ctrl_pkg.sv
// types shared by the watchdog control files
package wdt_ctrl_pkg;
    typedef enum logic [1:0] {
        st_idle,
        st_wait_ack
    } sync_state_e;
    typedef logic [7:0] ctrl_byte_t;
endpackage

// file: rtl/wdt_bit_sync.sv
// two-flop synchroniser for one level
`timescale 1ns/1ps
module wdt_bit_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);
    logic meta_q;

    // first flop is read only by the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            dout   <= 1'b0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule // wdt_bit_sync

// file: rtl/wdt_ctrl_shadow.sv
// watchdog-side copy of the control byte, loaded by a toggle handshake
`timescale 1ns/1ps
module wdt_ctrl_shadow
    import wdt_ctrl_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    req_tgl,
    input  wire wdt_ctrl_pkg::ctrl_byte_t data,
    output wdt_ctrl_pkg::ctrl_byte_t      shadow,
    output logic                         ack_tgl
);
    logic req_s;

    wdt_bit_sync u_req (
        .clk   (clk),
        .rst_n (rst_n),
        .din   (req_tgl),
        .dout  (req_s)
    );

    // data is stable while the request toggle is pending
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shadow  <= 8'h00;
            ack_tgl <= 1'b0;
        end else if (req_s != ack_tgl) begin
            shadow  <= data;
            ack_tgl <= req_s;
        end
    end
endmodule // wdt_ctrl_shadow

// file: testbench/wdt_ctrl_lock_sva.sv
// port-level assertions for the watchdog control block
`timescale 1ns/1ps
module wdt_ctrl_lock_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        nvm_lock,
    input wire logic        standby_sleep,
    input wire logic        sync_busy,
    input wire logic        wdt_running,
    input wire logic        wdt_count_en,
    input wire logic        wdt_window_mode,
    input wire logic [7:0]  period_config
);
    logic acc;
    logic locked_q;
    logic seen_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign acc = psel && penable && pready;
    // conservative lock tracking: any lock request disables open checks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locked_q <= 1'b0;
            seen_q   <= 1'b0;
        end else begin
            if (nvm_lock || (acc && pwrite && paddr == 12'h000 && pwdata[7]))
                locked_q <= 1'b1;
            if (acc && !pwrite && paddr == 12'h000 && prdata[7])
                seen_q <= 1'b1;
        end
    end
    busy_after_write_a: assert property (acc && pwrite && paddr == 12'h000
        && !sync_busy && !locked_q |=> sync_busy) else $error("busy not raised");
    busy_bounded_a: assert property ($rose(sync_busy) |-> ##[1:60] !sync_busy)
        else $error("busy stuck");
    ready_one_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("access phase not one cycle");
    count_gate_a: assert property (wdt_count_en |-> wdt_running)
        else $error("counting while stopped");
    lock_sticky_a: assert property (seen_q |-> wdt_running)
        else $error("locked watchdog stopped");
    lock_ro_a: assert property (seen_q && acc && pwrite && paddr == 12'h004
        |=> $stable(period_config)) else $error("locked period changed");
    period_write_a: assert property (acc && pwrite && paddr == 12'h004
        && !locked_q |=> period_config == $past(pwdata[7:0]))
        else $error("period write lost");
    win_protect_a: assert property (wdt_running && $past(wdt_running)
        && !locked_q |-> $stable(wdt_window_mode)) else $error("window changed");
    cover property (acc && pwrite && paddr == 12'h000);
    cover property ($rose(seen_q));
    cover property (wdt_count_en && standby_sleep);
endmodule // wdt_ctrl_lock_sva

bind wdt_ctrl_lock wdt_ctrl_lock_sva u_sva (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .nvm_lock, .standby_sleep,
    .sync_busy, .wdt_running, .wdt_count_en, .wdt_window_mode, .period_config);

// file: testbench/wdt_ctrl_lock_tb.sv
// self-checking bench for the watchdog control block
`timescale 1ns/1ps
`define CHK(n, e, v) begin total_checks++; if ((v) !== (e)) begin \
    num_errors++; $display("MISMATCH %s exp %0h got %0h", n, e, v); end end
module wdt_ctrl_lock_tb;
    import wdt_ctrl_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, wdt_clk = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic nvm_load = 1'b0, nvm_stdby = 1'b0, nvm_win = 1'b0, sleep = 1'b0;
    logic nvm_lk = 1'b0;
    logic e, run, cnt, win, busy;
    logic [7:0] per, ew;
    int num_errors = 0, total_checks = 0;
    always #2.5 pclk = ~pclk;
    // watchdog clock deliberately unrelated to pclk
    always #3.7 wdt_clk = ~wdt_clk;
    wdt_ctrl_lock u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wdt_clk(wdt_clk), .nvm_load(nvm_load), .nvm_lock(nvm_lk),
        .nvm_stdby_run(nvm_stdby), .nvm_window_en(nvm_win),
        .nvm_enable(1'b0), .standby_sleep(sleep), .wdt_running(run),
        .wdt_count_en(cnt), .wdt_window_mode(win), .sync_busy(busy),
        .period_config(per), .early_warning_setup(ew));
    task final_report;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one apb transfer; k keeps psel up for a back-to-back setup
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             input logic k);
        int n;
        n = 0;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin num_errors++; final_report; end
        r = prdata; e = pslverr;
        penable <= 1'b0;
        if (!k) psel <= 1'b0;
    endtask
    task idle;
        int n;
        n = 0;
        repeat (2) @(posedge pclk);
        while (busy !== 1'b0 && n < 100) begin @(posedge pclk); n++; end
        if (n >= 100) begin num_errors++; final_report; end
        repeat (3) @(posedge pclk);
    endtask
    task wc(input logic [7:0] d);
        apb(1'b1, 12'h000, {24'h0, d}, 1'b0);
        idle;
    endtask
    task rdc(input logic [11:0] a);
        apb(1'b0, a, 32'h0, 1'b0);
    endtask
    task t_load;
        nvm_stdby <= 1'b1; nvm_win <= 1'b1; nvm_load <= 1'b1;
        repeat (6) @(posedge pclk);
        idle;
        rdc(12'h000); `CHK("ctrl", 32'h44, r)
        `CHK("window", 1'b1, win)
    endtask
    task t_protect;
        wc(8'h00); wc(8'h02); sleep <= 1'b1;
        repeat (6) @(posedge pclk);
        `CHK("running", 1'b1, run)
        `CHK("count", 1'b0, cnt)
        wc(8'h46); rdc(12'h000); `CHK("ctrl", 32'h02, r)
        apb(1'b1, 12'h000, 32'h0, 1'b1);
        apb(1'b1, 12'h000, 32'h44, 1'b0);
        idle; rdc(12'h000); `CHK("ctrl", 32'h00, r)
        `CHK("running", 1'b0, run)
        wc(8'h44); `CHK("window", 1'b1, win)
        wc(8'h46); `CHK("count", 1'b1, cnt)
    endtask
    task t_regs;
        apb(1'b1, 12'h004, 32'hA5, 1'b0); apb(1'b1, 12'h008, 32'hFF, 1'b0);
        @(posedge pclk);
        `CHK("period", 8'hA5, per)
        `CHK("warning", 8'h0F, ew)
        rdc(12'h010); `CHK("slverr", 1'b1, e)
        apb(1'b1, 12'h000, 32'h46, 1'b0);
        rdc(12'h00C); `CHK("busy", 32'h1, r)
        idle;
    endtask
    task t_lock;
        wc(8'hC6); rdc(12'h000); `CHK("ctrl", 32'hC6, r)
        wc(8'h00); rdc(12'h000); `CHK("ctrl", 32'hC6, r)
        apb(1'b1, 12'h004, 32'h11, 1'b0); apb(1'b1, 12'h008, 32'h03, 1'b0);
        @(posedge pclk);
        `CHK("period", 8'hA5, per)
        `CHK("warning", 8'h0F, ew)
        `CHK("running", 1'b1, run)
    endtask
    // power-on reset is the only way out of the lock
    task t_por;
        nvm_load <= 1'b0; presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(12'h000); `CHK("ctrl", 32'h00, r)
        `CHK("running", 1'b0, run)
        nvm_lk <= 1'b1; nvm_load <= 1'b1;
        repeat (6) @(posedge pclk);
        idle;
        rdc(12'h000); `CHK("ctrl", 32'hC6, r)
        `CHK("running", 1'b1, run)
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_load; t_protect; t_regs; t_lock; t_por;
        final_report;
    end
endmodule // wdt_ctrl_lock_tb
